// ==== logic/reset_and_watchdog_control.sv ====
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module reset_and_watchdog_control
  import rstwd_pkg::*;
#(
  parameter int SUPPLY_TIMEOUT_NS = 100000
)(
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire logic              SUPPLY_RST,
  input  wire logic              PIN_RST_N_IN,
  input  wire logic              CMP0_RST,
  input  wire logic              MISSCLK_RST,
  output logic                   PIN_RST_N_OUT,
  output logic                   PIN_RST_N_OE_N,
  output core_ctl_t              CORE_CTL,
  output cause_t                 LAST_CAUSE,
  input  wire logic [11:0]       S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [11:0]       S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY
);

  localparam int SUPPLY_CYC = (SUPPLY_TIMEOUT_NS / int'(CLK_PERIOD_NS) < 1) ? 1 :
                              SUPPLY_TIMEOUT_NS / int'(CLK_PERIOD_NS);
  localparam int WD_CNT_W   = 2 * (WD_BASE_EXP + int'(WD_INTERVAL_RST)) + 1;

  rst_state_t  state_r;
  logic [2:0]  interval_r;
  logic        wd_active_r;
  logic        lock_r;
  logic [2:0]  dis_win_r;
  logic [WD_CNT_W-1:0] wd_cnt_r;
  logic [31:0] hold_cnt_r;
  logic        soft_force_r;
  logic        pin_drive_r;
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic        wr_fire;
  logic        wd_expire;
  logic        any_cause;
  logic [7:0]  wbyte;
  cause_t      cause_nxt;
  logic [WD_CNT_W-1:0] wd_limit;

  assign wr_fire   = aw_hold_r && w_hold_r && !S_AXI_BVALID;
  assign wbyte     = w_data_r[7:0];
  assign wd_limit  = WD_CNT_W'(WD_CNT_W'(1) << (2 * (WD_BASE_EXP + int'(interval_r))));
  assign wd_expire = wd_active_r && (wd_cnt_r == wd_limit - WD_CNT_W'(1));

  always_comb
  begin
    cause_nxt = CAUSE_NONE;
    if (SUPPLY_RST)
      cause_nxt = CAUSE_SUPPLY;
    else if (!PIN_RST_N_IN && !pin_drive_r && PIN_RST_N_OE_N)
      cause_nxt = CAUSE_PIN;
    else if (soft_force_r)
      cause_nxt = CAUSE_SOFT;
    else if (CMP0_RST)
      cause_nxt = CAUSE_CMP0;
    else if (MISSCLK_RST)
      cause_nxt = CAUSE_MISSCLK;
    else if (wd_expire)
      cause_nxt = CAUSE_WDOG;
  end
  assign any_cause = (cause_nxt != CAUSE_NONE);

  // AXI write channel
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      aw_addr_r     <= '0;
      w_data_r      <= '0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OKAY;
    end
    else
    begin
      S_AXI_AWREADY <= !aw_hold_r && !(S_AXI_AWVALID && S_AXI_AWREADY);
      S_AXI_WREADY  <= !w_hold_r && !(S_AXI_WVALID && S_AXI_WREADY);
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_hold_r <= 1'b1;
        w_data_r <= S_AXI_WSTRB[0] ? S_AXI_WDATA : 32'h0000_0000;
      end
      if (wr_fire)
      begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (aw_addr_r == ADDR_WDCTL || aw_addr_r == ADDR_RSTCTL ||
                         aw_addr_r == ADDR_RSTSTAT) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
      begin
        S_AXI_BVALID <= 1'b0;
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // AXI read channel
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= '0;
      S_AXI_RRESP   <= RESP_OKAY;
    end
    else
    begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
      if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= RESP_OKAY;
        S_AXI_RDATA  <= '0;
        unique case (S_AXI_ARADDR)
          ADDR_WDCTL:
          begin
            S_AXI_RDATA[2:0]           <= interval_r;
            S_AXI_RDATA[WD_STATUS_BIT] <= wd_active_r;
          end
          ADDR_RSTCTL:  S_AXI_RDATA[RSTCTL_FORCE] <= soft_force_r;
          ADDR_RSTSTAT: S_AXI_RDATA[2:0] <= LAST_CAUSE;
          default:      S_AXI_RRESP <= RESP_SLVERR;
        endcase
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end
  end

  // Watchdog key decoding and counting
  always_ff @(posedge CLK)
  begin
    if (!RST_N || state_r != ST_RUN)
    begin
      interval_r  <= WD_INTERVAL_RST;
      wd_active_r <= 1'b1;
      lock_r      <= 1'b0;
      dis_win_r   <= '0;
      wd_cnt_r    <= '0;
    end
    else
    begin
      wd_cnt_r  <= wd_active_r ? wd_cnt_r + WD_CNT_W'(1) : '0;
      dis_win_r <= (dis_win_r != '0) ? dis_win_r - 3'h1 : '0;
      if (wr_fire && aw_addr_r == ADDR_WDCTL)
      begin
        if (wbyte == WD_KEY_ENABLE)
        begin
          wd_active_r <= 1'b1;
          wd_cnt_r    <= '0;
        end
        else if (wbyte == WD_KEY_DIS1)
          dis_win_r <= WD_DIS_WIN_W;
        else if (wbyte == WD_KEY_DIS2)
        begin
          if (dis_win_r != '0 && !lock_r)
          begin
            wd_active_r <= 1'b0;
            wd_cnt_r    <= '0;
          end
        end
        else if (wbyte == WD_KEY_LOCK)
          lock_r <= 1'b1;
        else if (!wbyte[WD_MSB_BIT])
          interval_r <= wbyte[2:0];
      end
    end
  end

  // Software reset force flag; cleared once the state leaves ST_RUN
  always_ff @(posedge CLK)
  begin
    if (!RST_N || state_r != ST_RUN)
      soft_force_r <= 1'b0;
    else if (wr_fire && aw_addr_r == ADDR_RSTCTL && wbyte[RSTCTL_FORCE])
      soft_force_r <= 1'b1;
  end

  // Reset sequencer
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      state_r     <= ST_RESET;
      hold_cnt_r  <= '0;
      pin_drive_r <= 1'b0;
      LAST_CAUSE  <= CAUSE_NONE;
    end
    else
    begin
      unique case (state_r)
        ST_RESET:
        begin
          hold_cnt_r <= '0;
          if (!any_cause)
            state_r <= ST_CLKWAIT;
        end
        ST_PINHOLD:
        begin
          pin_drive_r <= 1'b1;
          hold_cnt_r  <= hold_cnt_r + 32'h1;
          if (hold_cnt_r >= 32'(SUPPLY_CYC - 1) && !SUPPLY_RST)
          begin
            pin_drive_r <= 1'b0;
            hold_cnt_r  <= '0;
            state_r     <= ST_CLKWAIT;
          end
        end
        ST_CLKWAIT:
        begin
          hold_cnt_r <= hold_cnt_r + 32'h1;
          if (hold_cnt_r >= 32'(CLK_STABLE_CYC - 1))
            state_r <= ST_RUN;
        end
        ST_RUN: ;
      endcase
      if (any_cause && !(state_r == ST_PINHOLD))
      begin
        LAST_CAUSE <= cause_nxt;
        hold_cnt_r <= '0;
        state_r    <= (cause_nxt == CAUSE_SUPPLY || cause_nxt == CAUSE_SOFT) ? ST_PINHOLD : ST_RESET;
      end
    end
  end

  // Core control outputs; data memory is not driven from here
  always_ff @(posedge CLK)
  begin
    if (!RST_N || state_r != ST_RUN)
    begin
      CORE_CTL.halt        <= 1'b1;
      CORE_CTL.irq_tmr_dis <= 1'b1;
      CORE_CTL.load_pc     <= 1'b1;
      CORE_CTL.port_latch  <= PORT_RST_VAL;
      CORE_CTL.stack_top   <= STACK_RST_VAL;
      CORE_CTL.clk_sel     <= CLK_SEL_INT2MHZ;
      CORE_CTL.pullup_en   <= 1'b1;
    end
    else
    begin
      CORE_CTL.halt        <= 1'b0;
      CORE_CTL.irq_tmr_dis <= 1'b0;
      CORE_CTL.load_pc     <= 1'b0;
      CORE_CTL.pullup_en   <= 1'b1;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      PIN_RST_N_OUT  <= 1'b1;
      PIN_RST_N_OE_N <= 1'b1;
    end
    else
    begin
      PIN_RST_N_OUT  <= 1'b0;
      PIN_RST_N_OE_N <= !(state_r == ST_PINHOLD);
    end
  end

  property p_lock_blocks;
    @(posedge CLK) disable iff (!RST_N)
    lock_r && wd_active_r && state_r == ST_RUN |=> wd_active_r || state_r != ST_RUN;
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("disable accepted after lockout");

  property p_enable_key;
    @(posedge CLK) disable iff (!RST_N)
    wr_fire && aw_addr_r == ADDR_WDCTL && wbyte == WD_KEY_ENABLE && state_r == ST_RUN
      && !any_cause |=> wd_active_r && wd_cnt_r == '0;
  endproperty
  a_enable_key: assert property (p_enable_key) else $error("enable key did not restart");

  property p_late_disable;
    @(posedge CLK) disable iff (!RST_N)
    wd_active_r && dis_win_r == '0 && state_r == ST_RUN && !any_cause |=> wd_active_r;
  endproperty
  a_late_disable: assert property (p_late_disable) else $error("watchdog disabled without window");

  property p_lock_no_restart;
    @(posedge CLK) disable iff (!RST_N)
    wr_fire && aw_addr_r == ADDR_WDCTL && wbyte == WD_KEY_LOCK && state_r == ST_RUN && wd_active_r
      && !any_cause |=> wd_cnt_r == $past(wd_cnt_r) + WD_CNT_W'(1);
  endproperty
  a_lock_no_restart: assert property (p_lock_no_restart) else $error("lockout restarted count");

  property p_expire_reset;
    @(posedge CLK) disable iff (!RST_N)
    wd_expire && state_r == ST_RUN |=> state_r == ST_RESET ##1 CORE_CTL.halt;
  endproperty
  a_expire_reset: assert property (p_expire_reset) else $error("watchdog expiry did not reset");

  property p_run_clean;
    @(posedge CLK) disable iff (!RST_N)
    state_r != ST_RUN |=> CORE_CTL.halt && CORE_CTL.port_latch == PORT_RST_VAL;
  endproperty
  a_run_clean: assert property (p_run_clean) else $error("core not held in reset state");

  property p_pin_drive;
    @(posedge CLK) disable iff (!RST_N)
    state_r == ST_PINHOLD |=> !PIN_RST_N_OE_N && !PIN_RST_N_OUT;
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("reset pin not driven low");

  property p_post_reset_wd;
    @(posedge CLK) disable iff (!RST_N)
    $rose(state_r == ST_RUN) |-> wd_active_r && interval_r == WD_INTERVAL_RST;
  endproperty
  a_post_reset_wd: assert property (p_post_reset_wd) else $error("watchdog defaults wrong");

  c_disable: cover property (@(posedge CLK) disable iff (!RST_N) $fell(wd_active_r) && state_r == ST_RUN);
  c_expire: cover property (@(posedge CLK) disable iff (!RST_N) wd_expire);
  c_softrst: cover property (@(posedge CLK) disable iff (!RST_N) state_r == ST_PINHOLD);

endmodule : reset_and_watchdog_control

// ==== logic/rstwd_pkg.sv ====
package rstwd_pkg;

  localparam logic [7:0]  WD_KEY_ENABLE   = 8'hA5;
  localparam logic [7:0]  WD_KEY_DIS1     = 8'hDE;
  localparam logic [7:0]  WD_KEY_DIS2     = 8'hAD;
  localparam logic [7:0]  WD_KEY_LOCK     = 8'hFF;
  localparam int          WD_DIS_WINDOW   = 4;
  localparam logic [2:0]  WD_DIS_WIN_W    = 3'h4;
  localparam logic [2:0]  WD_INTERVAL_RST = 3'h7;
  localparam int          WD_STATUS_BIT   = 4;
  localparam int          WD_MSB_BIT      = 7;
  localparam int          WD_BASE_EXP     = 3;

  localparam logic [7:0]  PORT_RST_VAL    = 8'hFF;
  localparam logic [7:0]  STACK_RST_VAL   = 8'h07;
  localparam logic [15:0] PC_RST_VAL      = 16'h0000;
  localparam logic [1:0]  CLK_SEL_INT2MHZ = 2'h0;

  localparam real         CLK_PERIOD_NS   = 4.0;
  localparam int          CLK_STABLE_CYC  = 16;

  localparam logic [11:0] ADDR_WDCTL      = 12'h000;
  localparam logic [11:0] ADDR_RSTCTL     = 12'h004;
  localparam logic [11:0] ADDR_RSTSTAT    = 12'h008;
  localparam int          RSTCTL_FORCE    = 0;

  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [2:0] {
    CAUSE_NONE,
    CAUSE_SUPPLY,
    CAUSE_PIN,
    CAUSE_SOFT,
    CAUSE_CMP0,
    CAUSE_MISSCLK,
    CAUSE_WDOG
  } cause_t;

  typedef enum {ST_RESET, ST_PINHOLD, ST_CLKWAIT, ST_RUN} rst_state_t;

  typedef struct packed {
    logic        halt;
    logic        load_pc;
    logic [7:0]  port_latch;
    logic        pullup_en;
    logic [7:0]  stack_top;
    logic [1:0]  clk_sel;
    logic        irq_tmr_dis;
  } core_ctl_t;

endpackage : rstwd_pkg

// ==== verif/reset_and_watchdog_control_tb.sv ====
`timescale 1ns/10ps
module reset_and_watchdog_control_tb;
  import rstwd_pkg::*;
  logic        clk, rst_n, sup, pin_n, cmp, mck;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd, v;
  logic        awv, wv, bre, arv, rre, po, poe, awr, wr, bv, arr, rv, drove;
  logic [1:0]  br, rr, r;
  wire         pin_in;
  core_ctl_t   cc;
  cause_t      lc;
  int          n_mismatch, n_tests, cnt, t_de, m_iv, m_act, m_lock, n, k;

  // Reset pin with pull-up, pulled low when driven
  assign pin_in = pin_n & (poe | po);

  reset_and_watchdog_control #(.SUPPLY_TIMEOUT_NS(40)) reset_and_watchdog_control_i (
    .CLK(clk), .RST_N(rst_n), .SUPPLY_RST(sup), .PIN_RST_N_IN(pin_in), .CMP0_RST(cmp),
    .MISSCLK_RST(mck), .PIN_RST_N_OUT(po), .PIN_RST_N_OE_N(poe), .CORE_CTL(cc), .LAST_CAUSE(lc),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cnt <= cnt + 1;
    if (poe === 1'b0 && po === 1'b0)
      drove <= 1'b1;
    if (cnt == 20000)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  task stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic axw(input logic [11:0] a, input logic [7:0] d, output logic [1:0] rs);
    logic ga, gw;
    ga = 1'b0;
    gw = 1'b0;
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(ga && gw))
    begin
      @(posedge clk);
      if (awr)
        awv <= 1'b0;
      if (wr)
        wv <= 1'b0;
      ga = ga | awr;
      gw = gw | wr;
    end
    bre <= 1'b1;
    do @(posedge clk); while (bv !== 1'b1);
    rs = br;
    bre <= 1'b0;
  endtask : axw

  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
    ara <= a;
    arv <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    rre <= 1'b1;
    do @(posedge clk); while (rv !== 1'b1);
    d = rd;
    rs = rr;
    rre <= 1'b0;
  endtask : axr

  // Watchdog write, with the reference model following the keys
  task automatic ww(input logic [7:0] d);
    axw(ADDR_WDCTL, d, r);
    chk(r, RESP_OKAY);
    if (d == WD_KEY_ENABLE)
      m_act = 1;
    else if (d == WD_KEY_LOCK)
      m_lock = 1;
    else if (d == WD_KEY_DIS2)
    begin
      if (cnt - t_de <= WD_DIS_WINDOW && m_lock == 0)
        m_act = 0;
    end
    else if (d == WD_KEY_DIS1)
      t_de = cnt;
    else if (!d[7])
      m_iv = d[2:0];
  endtask : ww

  task rw;
    axr(ADDR_WDCTL, v, r);
    chk(r, RESP_OKAY);
    chk(v, (m_act << WD_STATUS_BIT) | m_iv);
  endtask : rw

  task mrst;
    m_iv = 7;
    m_act = 1;
    m_lock = 0;
  endtask : mrst

  task crst;
    chk(cc.halt & cc.load_pc & cc.irq_tmr_dis & cc.pullup_en, 1);
    chk(32'({cc.port_latch, cc.stack_top, cc.clk_sel}), 32'({PORT_RST_VAL, STACK_RST_VAL, CLK_SEL_INT2MHZ}));
  endtask : crst

  // Cycles until halt reaches the given level
  task automatic wt(input logic lv);
    n = 0;
    while (cc.halt !== lv && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
  endtask : wt

  initial
  begin
    {rst_n, sup, cmp, mck, awv, wv, bre, arv, rre, drove} = '0;
    pin_n = 1'b1;
    awa = '0;
    ara = '0;
    wd = '0;
    {n_mismatch, n_tests, cnt} = '0;
    t_de = -100;
    mrst();
    v = $urandom(32'hCCD3);
    repeat (12) @(posedge clk);
    crst();
    chk(poe, 1'b1);
    rst_n <= 1'b1;
    wt(1'b0);
    chk(n >= CLK_STABLE_CYC, 1);
    chk({cc.pullup_en, cc.clk_sel}, {1'b1, CLK_SEL_INT2MHZ});
    rw();
    axr(12'hFFC, v, r);
    chk(r, RESP_SLVERR);
    axw(12'hFFC, WD_KEY_ENABLE, r);
    chk(r, RESP_SLVERR);
    ww(WD_KEY_DIS1);
    repeat (10) @(posedge clk);
    ww(WD_KEY_DIS2);
    rw();
    ww(WD_KEY_DIS1);
    ww(WD_KEY_DIS2);
    rw();
    repeat (6)
    begin
      ww(8'($urandom) & 8'h7F);
      rw();
    end
    ww(WD_KEY_LOCK);
    rw();
    ww(WD_KEY_ENABLE);
    rw();
    ww(WD_KEY_DIS1);
    ww(WD_KEY_DIS2);
    rw();
    ww(8'h01);
    ww(WD_KEY_ENABLE);
    repeat (3)
    begin
      repeat (200) @(posedge clk);
      chk(cc.halt, 1'b0);
      ww(WD_KEY_ENABLE);
    end
    wt(1'b1);
    chk(n >= 248 && n <= 264, 1);
    chk(lc, CAUSE_WDOG);
    mrst();
    wt(1'b0);
    rw();
    ww(WD_KEY_DIS1);
    ww(WD_KEY_DIS2);
    rw();
    ww(8'h00);
    ww(WD_KEY_ENABLE);
    wt(1'b1);
    chk(n >= 56 && n <= 72, 1);
    wt(1'b0);
    for (k = 1; k <= 5; k++)
    begin
      drove = 1'b0;
      sup <= (k == 1);
      pin_n <= (k != 2);
      cmp <= (k == 4);
      mck <= (k == 5);
      if (k == 3)
        axw(ADDR_RSTCTL, 8'h01, r);
      repeat (4) @(posedge clk);
      crst();
      sup <= 1'b0;
      pin_n <= 1'b1;
      cmp <= 1'b0;
      mck <= 1'b0;
      wt(1'b0);
      chk(n >= CLK_STABLE_CYC, 1);
      chk(drove, k == 1 || k == 3);
      chk(lc, k);
      axr(ADDR_RSTSTAT, v, r);
      chk(v[2:0], k);
      mrst();
      rw();
    end
    stop_test();
  end
endmodule : reset_and_watchdog_control_tb
